// [logic/tcu_defines.svh]
/*
 * register offsets, field positions, reset values and mode codes of the
 * eight-bit timer compare unit.
 * assumes a 32-bit avalon-mm slave with word-aligned byte addresses.
 */
`ifndef TCU_DEFINES_SVH
`define TCU_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TCU_OFF_CTRL 5'h00
`define TCU_OFF_COUNT 5'h04
`define TCU_OFF_CMPA 5'h08
`define TCU_OFF_CMPB 5'h0c
`define TCU_OFF_FLAGS 5'h10
`define TCU_OFF_IRQEN 5'h14
`define TCU_OFF_ACK 5'h18
`define TCU_OFF_PORT 5'h1c

// ****************************************
// control register fields
// ****************************************
`define TCU_CTRL_MODE_LSB 0
`define TCU_CTRL_ACTA_LSB 4
`define TCU_CTRL_ACTB_LSB 6
`define TCU_CTRL_RUN_BIT 8
`define TCU_CTRL_FORCEA_BIT 16
`define TCU_CTRL_FORCEB_BIT 17

// ****************************************
// flag bits
// ****************************************
`define TCU_FLAG_WRAP 0
`define TCU_FLAG_MA 1
`define TCU_FLAG_MB 2

// ****************************************
// mode codes and limits
// ****************************************
`define TCU_MODE_NORMAL 3'h0
`define TCU_MODE_PC_FF 3'h1
`define TCU_MODE_CTC 3'h2
`define TCU_MODE_FAST_FF 3'h3
`define TCU_MODE_PC_A 3'h5
`define TCU_MODE_FAST_A 3'h7
`define TCU_MAX 8'hff
`define TCU_BOTTOM 8'h00
`define TCU_RST_BYTE 8'h00

`endif

// [logic/tcu_pkg.sv]
/*
 * types of the eight-bit timer compare unit.
 * assumes tcu_defines.svh supplies the numbers.
 */
package tcu_pkg;

  typedef struct packed {
    logic [7:0] count;
    logic count_down;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [2:0] mode;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic run;
    logic [2:0] flags;
    logic [2:0] irq_en;
    logic [1:0] port_data;
    logic [1:0] port_dir;
    logic [1:0] wave;
    logic [1:0] match_pend;
    logic block;
    logic [31:0] rdata;
    logic rvalid;
  } tcu_state_t;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } tcu_pins_t;

endpackage : tcu_pkg

// [logic/tcu_compare_unit.sv]
/*
 * two-channel output compare, wave output and 8-bit counter with mode
 * select, behind an avalon-mm slave with waitrequest.
 * assumes tick is a one-cycle timer clock enable on sys_clk from a
 * prescaler outside, and that irq_ack pulses come from the interrupt
 * controller when a vector is taken.
 */
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "tcu_defines.svh"

module tcu_compare_unit (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [1:0] pin_sync
);

  tcu_pkg::tcu_state_t s_r;
  tcu_pkg::tcu_state_t s_nxt;
  tcu_pkg::tcu_pins_t pins_r;
  tcu_pkg::tcu_pins_t pins_nxt;
  logic [1:0] pin_meta_r;
  logic [1:0] pin_sync_r;

  logic wr;
  logic rd;
  logic pwm;
  logic fast;
  logic [7:0] top;
  logic at_top;
  logic at_bottom;
  logic [1:0] eq;
  logic [7:0] cmp_sel [2];
  logic [1:0] act_sel [2];
  logic tclk;

  // ****************************************
  // decode
  // ****************************************
  // reads answer one cycle after the request, writes with no wait
  assign wr = avs_write && !avs_read;
  assign rd = avs_read && !avs_write;
  assign avs_waitrequest = rd && !s_r.rvalid;
  assign avs_readdata = s_r.rdata;
  assign irq_req = s_r.flags & s_r.irq_en;
  assign pin_out = pins_r.out;
  assign pin_oe = pins_r.oe;
  assign pin_sync = pin_sync_r;

  assign pwm = s_r.mode[0];
  assign fast = s_r.mode[1] && s_r.mode[0];
  assign top = s_r.mode[2] ? s_r.cmp_a : `TCU_MAX;
  assign at_top = (s_r.count == top);
  assign at_bottom = (s_r.count == `TCU_BOTTOM);
  assign cmp_sel[0] = s_r.cmp_a;
  assign cmp_sel[1] = s_r.cmp_b;
  assign act_sel[0] = s_r.act_a;
  assign act_sel[1] = s_r.act_b;
  assign eq[0] = (s_r.count == cmp_sel[0]);
  assign eq[1] = (s_r.count == cmp_sel[1]);
  // run stands in for the clock select, so a stopped timer sees no tick
  assign tclk = tick && s_r.run;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] cnt_next;
    logic dn_next;
    logic cnt_wr;
    logic [1:0] force_s;
    logic [1:0] hit;
    logic reached_bottom;
    logic [1:0] act_new [2];
    logic [1:0] act_use;
    cnt_next = s_r.count;
    dn_next = s_r.count_down;
    cnt_wr = wr && avs_address == `TCU_OFF_COUNT && avs_byteenable[0];
    force_s = 2'h0;
    hit = 2'h0;
    reached_bottom = 1'b0;
    act_new[0] = s_r.act_a;
    act_new[1] = s_r.act_b;
    act_use = 2'h0;
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;

    // counting depends on the mode bits, and on compare a for ctc and the a-top modes
    if (tclk) begin
      case (s_r.mode)
        `TCU_MODE_NORMAL: cnt_next = s_r.count + 8'h01;
        `TCU_MODE_CTC: cnt_next = eq[0] ? `TCU_BOTTOM
                                         : s_r.count + 8'h01;
        `TCU_MODE_FAST_FF, `TCU_MODE_FAST_A:
          cnt_next = at_top ? `TCU_BOTTOM : s_r.count + 8'h01;
        `TCU_MODE_PC_FF, `TCU_MODE_PC_A: begin
          if (!s_r.count_down && at_top) begin
            dn_next = 1'b1;
            cnt_next = s_r.count - 8'h01;
          end else if (s_r.count_down && at_bottom) begin
            dn_next = 1'b0;
            cnt_next = s_r.count + 8'h01;
          end else begin
            cnt_next = s_r.count_down ? s_r.count - 8'h01
                                      : s_r.count + 8'h01;
          end
        end
        default: cnt_next = s_r.count + 8'h01;
      endcase
      reached_bottom = (cnt_next == `TCU_BOTTOM) && !at_bottom;
      // a clear on match is no overflow; ctc flags only max to zero
      if (s_r.mode == `TCU_MODE_CTC)
        reached_bottom = reached_bottom && (s_r.count == `TCU_MAX);
      // wrap flag: normal/ctc on overflow, fast at top, pc at bottom
      if (fast ? at_top : reached_bottom)
        s_nxt.flags[`TCU_FLAG_WRAP] = 1'b1;
      // buffered compare loads at top (fast) or bottom (pc)
      if (pwm && (fast ? at_top : reached_bottom)) begin
        s_nxt.cmp_a = s_r.buf_a;
        s_nxt.cmp_b = s_r.buf_b;
      end
    end
    s_nxt.count = cnt_next;
    s_nxt.count_down = dn_next;

    // matches are taken on the tick, blocked after a counter write
    // the block lasts until a real timer tick, even while stopped
    if (tclk && !s_r.block)
      hit = eq;
    if (tclk)
      s_nxt.block = 1'b0;

    // flag sets one tick later via the pending register
    if (tclk) begin
      if (s_r.match_pend[0]) s_nxt.flags[`TCU_FLAG_MA] = 1'b1;
      if (s_r.match_pend[1]) s_nxt.flags[`TCU_FLAG_MB] = 1'b1;
      s_nxt.match_pend = hit;
    end

    // ****************************************
    // register writes
    // ****************************************
    if (wr) begin
      case (avs_address)
        `TCU_OFF_CTRL: begin
          if (avs_byteenable[0]) begin
            s_nxt.mode = avs_writedata[`TCU_CTRL_MODE_LSB +: 3];
            s_nxt.act_a = avs_writedata[`TCU_CTRL_ACTA_LSB +: 2];
            s_nxt.act_b = avs_writedata[`TCU_CTRL_ACTB_LSB +: 2];
          end
          if (avs_byteenable[1])
            s_nxt.run = avs_writedata[`TCU_CTRL_RUN_BIT];
          // strobes are not stored anywhere
          if (avs_byteenable[2] && !pwm)
            force_s = {avs_writedata[`TCU_CTRL_FORCEB_BIT],
                       avs_writedata[`TCU_CTRL_FORCEA_BIT]};
        end
        `TCU_OFF_COUNT: begin
          if (cnt_wr) begin
            s_nxt.count = avs_writedata[7:0];
            s_nxt.block = 1'b1;
          end
        end
        `TCU_OFF_CMPA: begin
          if (avs_byteenable[0]) begin
            s_nxt.buf_a = avs_writedata[7:0];
            if (!pwm) s_nxt.cmp_a = avs_writedata[7:0];
          end
        end
        `TCU_OFF_CMPB: begin
          if (avs_byteenable[0]) begin
            s_nxt.buf_b = avs_writedata[7:0];
            if (!pwm) s_nxt.cmp_b = avs_writedata[7:0];
          end
        end
        `TCU_OFF_IRQEN: begin
          if (avs_byteenable[0]) s_nxt.irq_en = avs_writedata[2:0];
        end
        `TCU_OFF_PORT: begin
          if (avs_byteenable[0]) begin
            s_nxt.port_data = avs_writedata[1:0];
            s_nxt.port_dir = avs_writedata[5:4];
          end
        end
        default: ;
      endcase
    end
    // a force acts with the action written in the same access
    act_new[0] = s_nxt.act_a;
    act_new[1] = s_nxt.act_b;

    // software and service clears; a same-cycle set wins only when the flag was clear
    for (int i = 0; i < 3; i++) begin
      if ((wr && avs_address == `TCU_OFF_FLAGS && avs_byteenable[0]
           && avs_writedata[i]) || irq_ack[i]) begin
        if (!(s_nxt.flags[i] && !s_r.flags[i]))
          s_nxt.flags[i] = 1'b0;
      end
    end

    // ****************************************
    // wave output
    // ****************************************
    // the wave register is never reset by a mode change
    for (int c = 0; c < 2; c++) begin
      act_use = force_s[c] ? act_new[c] : act_sel[c];
      if (hit[c] || force_s[c]) begin
        if (!pwm) begin
          case (act_use)
            2'h1: s_nxt.wave[c] = !s_r.wave[c];
            2'h2: s_nxt.wave[c] = 1'b0;
            2'h3: s_nxt.wave[c] = 1'b1;
            default: ;
          endcase
        end else if (act_sel[c][1]) begin
          if (fast)
            s_nxt.wave[c] = act_sel[c][0];
          else
            s_nxt.wave[c] = act_sel[c][0] ^ s_r.count_down;
        end
      end
      if (pwm && fast && tclk && at_top && act_sel[c][1]
          && !hit[c])
        s_nxt.wave[c] = !act_sel[c][0];
    end

    // ****************************************
    // read data
    // ****************************************
    s_nxt.rdata = 32'h0;
    if (rd && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      case (avs_address)
        `TCU_OFF_CTRL: s_nxt.rdata = {23'h0, s_r.run, s_r.act_b,
                                      s_r.act_a, 1'b0, s_r.mode};
        `TCU_OFF_COUNT: s_nxt.rdata = {24'h0, s_r.count};
        `TCU_OFF_CMPA: s_nxt.rdata = {24'h0, pwm ? s_r.buf_a : s_r.cmp_a};
        `TCU_OFF_CMPB: s_nxt.rdata = {24'h0, pwm ? s_r.buf_b : s_r.cmp_b};
        `TCU_OFF_FLAGS: s_nxt.rdata = {29'h0, s_r.flags};
        `TCU_OFF_IRQEN: s_nxt.rdata = {29'h0, s_r.irq_en};
        `TCU_OFF_PORT: s_nxt.rdata = {24'h0, 2'h0, s_r.port_dir, 2'h0,
                                      s_r.port_data};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
  end

  // ****************************************
  // pin mux
  // ****************************************
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      // override independent of mode
      pins_nxt.out[c] = (act_sel[c] != 2'h0) ? s_r.wave[c]
                                             : s_r.port_data[c];
      pins_nxt.oe[c] = s_r.port_dir[c];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      pins_r <= '0;
      pin_meta_r <= 2'h0;
      pin_sync_r <= 2'h0;
    end else begin
      s_r <= s_nxt;
      pins_r <= pins_nxt;
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

endmodule : tcu_compare_unit

// [verif/tcu_pin_load.sv]
/* external load on the two wave pins.
   assumes pin_out and pin_oe of the compare unit; no pull on the lines. */
`timescale 1ns/10ps
module tcu_pin_load (
  input wire logic sys_clk,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] wire_lvl
);
  // ****************************************
  // wire resolution
  // ****************************************
  // an undriven line shows a moving pattern, never a held last value
  logic [1:0] float_r = 2'h1;
  always @(posedge sys_clk) begin
    float_r <= ~float_r;
  end
  assign wire_lvl = (pin_oe & pin_out) | (~pin_oe & float_r);
endmodule : tcu_pin_load

// [verif/tcu_compare_unit_properties.sv]
/* port checker of the timer compare unit, bound after the module.
   assumes one clock, sys_clk, and rst_n active low. */
`timescale 1ns/10ps
module tcu_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [2:0] irq_ack,
  input wire logic [2:0] irq_req,
  input wire logic [1:0] pin_in,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic [1:0] pin_sync
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // synchroniser holds stale data for two edges after reset
  logic [1:0] age_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      age_r <= 2'h0;
    end else if (age_r != 2'h3) begin
      age_r <= age_r + 2'h1;
    end
  end
  sequence s_wait;
    avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest;
  endsequence
  chk_read_wait: assert property ($rose(avs_read) |-> s_wait ##1 s_answer)
    else $error("read not answered after one wait cycle");
  chk_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was made to wait");
  chk_read_hold: assert property
    (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved while idle");
  chk_ack_clear: assert property (irq_ack[2] && !tick |=> !irq_req[2])
    else $error("serviced match request still high");
  chk_flag_cause: assert property
    ($rose(irq_req[2]) |-> $past(tick) || $past(avs_write))
    else $error("match request rose without a tick");
  chk_oe_cause: assert property
    (!$stable(pin_oe) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("pin direction moved without a write");
  chk_out_cause: assert property (!$stable(pin_out) |->
    $past(avs_write) || $past(avs_write, 2) || $past(tick) || $past(tick, 2))
    else $error("pin output moved without tick or write");
  chk_sync_two: assert property (age_r == 2'h3 |-> pin_sync == $past(pin_in, 2))
    else $error("pin sync is not a two stage copy");
endmodule : tcu_chk

bind tcu_compare_unit tcu_chk tcu_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n),
  .tick(tick), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .irq_ack(irq_ack), .irq_req(irq_req), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .pin_sync(pin_sync));

// [verif/tcu_compare_unit_tb.sv]
/* self-checking bench of the timer compare unit.
   assumes the pin load model and the bound checker. */
`timescale 1ns/10ps
`include "tcu_defines.svh"
module tcu_compare_unit_tb;
  // ****************************************
  // bench
  // ****************************************
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] irq_ack = 3'h0;
  logic [2:0] irq_req;
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] pin_sync;
  logic [31:0] rd;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  tcu_compare_unit tcu_compare_unit_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .tick(tick), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_ack(irq_ack), .irq_req(irq_req),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_sync(pin_sync));
  tcu_pin_load tcu_pin_load_inst (.sys_clk(sys_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .wire_lvl(pin_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // request held until the edge that sees waitrequest low; two quiet
  // edges follow so registered pins have settled before any compare
  task automatic bus(input logic rw, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rw;
    avs_write <= !rw;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : bus
  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge sys_clk);
      tick <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : ticks
  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 5'(i * 4), 32'h0);
      check(rd, 32'h0);
    end
    bus(1'b0, `TCU_OFF_COUNT, 32'hfe);
    bus(1'b0, `TCU_OFF_CMPA, 32'h00);
    bus(1'b0, `TCU_OFF_CMPB, 32'hff);
    bus(1'b0, `TCU_OFF_IRQEN, 32'h7);
    bus(1'b0, `TCU_OFF_CTRL, 32'h100);
    ticks(2);
    bus(1'b1, `TCU_OFF_FLAGS, 32'h0);
    check(rd, 32'h1);
    ticks(1);
    bus(1'b1, `TCU_OFF_FLAGS, 32'h0);
    check(rd, 32'h5);
    ticks(1);
    check(32'(irq_req), 32'h7);
    bus(1'b1, `TCU_OFF_COUNT, 32'h0);
    check(rd, 32'h02);
    bus(1'b0, `TCU_OFF_FLAGS, 32'h0);
    bus(1'b0, `TCU_OFF_FLAGS, 32'h2);
    bus(1'b1, `TCU_OFF_FLAGS, 32'h0);
    check(rd, 32'h5);
    irq_ack <= 3'h4;
    @(posedge sys_clk);
    irq_ack <= 3'h0;
    @(posedge sys_clk);
    check(32'(irq_req), 32'h1);
    bus(1'b0, `TCU_OFF_FLAGS, 32'h7);
    bus(1'b0, `TCU_OFF_COUNT, 32'h40);
    bus(1'b0, `TCU_OFF_CMPA, 32'h40);
    ticks(2);
    bus(1'b1, `TCU_OFF_FLAGS, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, `TCU_OFF_COUNT, 32'h3f);
    ticks(3);
    bus(1'b1, `TCU_OFF_FLAGS, 32'h0);
    check(rd, 32'h2);
    bus(1'b0, `TCU_OFF_FLAGS, 32'h7);
    bus(1'b0, `TCU_OFF_CTRL, 32'h10030);
    bus(1'b1, `TCU_OFF_FLAGS, 32'h0);
    check(rd, 32'h0);
    check(32'(pin_out), 32'h1);
    check(32'(pin_oe), 32'h0);
    bus(1'b0, `TCU_OFF_PORT, 32'h32);
    repeat (3) @(posedge sys_clk);
    check(32'(pin_oe), 32'h3);
    check(32'(pin_sync), 32'h3);
    check(32'(pin_out), 32'h3);
    bus(1'b0, `TCU_OFF_CTRL, 32'h10000);
    check(32'(pin_out), 32'h2);
    bus(1'b0, `TCU_OFF_CTRL, 32'h10);
    check(32'(pin_out), 32'h3);
    bus(1'b0, `TCU_OFF_CTRL, 32'h10010);
    check(32'(pin_out), 32'h2);
    bus(1'b1, `TCU_OFF_CTRL, 32'h0);
    check(rd, 32'h10);
    bus(1'b0, `TCU_OFF_PORT, 32'h33);
    bus(1'b0, `TCU_OFF_CTRL, 32'h23);
    check(32'(pin_out), 32'h2);
    bus(1'b0, `TCU_OFF_FLAGS, 32'h7);
    bus(1'b0, `TCU_OFF_COUNT, 32'h10);
    bus(1'b0, `TCU_OFF_CMPA, 32'h12);
    bus(1'b0, `TCU_OFF_CTRL, 32'h123);
    ticks(4);
    bus(1'b1, `TCU_OFF_CMPA, 32'h0);
    check(rd, 32'h12);
    bus(1'b1, `TCU_OFF_FLAGS, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, `TCU_OFF_COUNT, 32'hfe);
    ticks(2);
    bus(1'b1, `TCU_OFF_FLAGS, 32'h0);
    check(rd, 32'h1);
    check(32'(pin_out), 32'h3);
    ticks(20);
    bus(1'b1, `TCU_OFF_FLAGS, 32'h0);
    check(rd, 32'h7);
    check(32'(pin_out), 32'h2);
    bus(1'b0, `TCU_OFF_CTRL, 32'h101);
    bus(1'b0, `TCU_OFF_COUNT, 32'hfe);
    ticks(3);
    bus(1'b1, `TCU_OFF_COUNT, 32'h0);
    check(rd, 32'hfd);
    bus(1'b0, `TCU_OFF_CTRL, 32'h102);
    bus(1'b0, `TCU_OFF_COUNT, 32'h10);
    ticks(4);
    bus(1'b1, `TCU_OFF_COUNT, 32'h0);
    check(rd, 32'h01);
    stop_test();
  end
endmodule : tcu_compare_unit_tb
